// File: src/loop_cfg_pkg.sv
// Constants for the locked-loop clock configuration block.
// Assumes a 32-bit APB slave; register indices are scaled by four.
package loop_cfg_pkg;

	// ==========================================================
	// Register indices
	localparam logic [9:0]  IDX_CLOCK_SELECT     = 10'h028;
	localparam logic [9:0]  IDX_ENABLES_DIVIDERS = 10'h02a;
	localparam logic [9:0]  IDX_RATIO_INTEGER    = 10'h02b;
	localparam logic [9:0]  IDX_FRACTION         = 10'h02c;
	localparam logic [9:0]  IDX_REFERENCE        = 10'h02d;
	localparam logic [9:0]  IDX_STATUS           = 10'h02e;

	// ==========================================================
	// Field positions
	localparam int CTL1_DIGITAL_BIT  = 15;
	localparam int CTL1_ANALOG_BIT   = 14;
	localparam int CTL1_OUTDIV_HI    = 10;
	localparam int CTL1_OUTDIV_LO    = 8;
	localparam int CTL1_GAIN_HI      = 7;
	localparam int CTL1_GAIN_LO      = 4;
	localparam int CTL1_RATE_HI      = 2;
	localparam int CTL1_RATE_LO      = 0;
	localparam int CTL2_RATIO_HI     = 15;
	localparam int CTL2_RATIO_LO     = 11;
	localparam int CTL2_N_HI         = 9;
	localparam int CTL2_N_LO         = 0;
	localparam int CTL4_LOWREF_BIT   = 7;
	localparam int CTL4_FRAC_BIT     = 5;
	localparam int CTL4_INSEL_HI     = 1;
	localparam int CTL4_INSEL_LO     = 0;
	localparam int CLKSEL_BIT        = 11;
	localparam int STAT_LEVEL_BIT    = 0;
	localparam int STAT_ORDER_BIT    = 1;
	localparam int STAT_RESV_BIT     = 2;
	localparam int STAT_OSC_BIT      = 3;
	localparam int STAT_RUN_BIT      = 4;
	localparam int STAT_COUNT_LO     = 8;

	// ==========================================================
	// Writable masks and reset values
	localparam logic [15:0] CTL1_MASK  = 16'hc7f7;
	localparam logic [15:0] CTL2_MASK  = 16'hfbff;
	localparam logic [15:0] CTL4_MASK  = 16'h00a3;
	localparam logic [15:0] CTL1_RESET = 16'h0200;
	localparam logic [15:0] CTL2_RESET = 16'h7086;
	localparam logic [15:0] CTL3_RESET = 16'hc226;
	localparam logic [15:0] CTL4_RESET = 16'h0000;

	// ==========================================================
	// Code limits
	localparam logic [2:0]  OUTDIV_MAX_CODE = 3'h4;
	localparam logic [3:0]  GAIN_MAX_CODE   = 4'h8;
	localparam logic [2:0]  RATE_MAX_CODE   = 3'h5;
	localparam logic [5:0]  OUTDIV_BASE     = 6'h02;

	typedef enum logic [2:0] {
		ST_OFF = 3'b001,
		ST_OSC = 3'b010,
		ST_RUN = 3'b100
	} loop_state_t;

endpackage

// File: src/ref_sync_if.sv
// Carries the reference select and the synchronised reference level.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ref_sync_if;
	logic [1:0] select;
	logic       level;
	modport syncer (input select, output level);
	modport user   (output select, input level);
endinterface

// File: src/reference_synchroniser.sv
// Three-stage synchronisers for the four reference pins and the source mux.
// Assumes pins are asynchronous to clock_i.
`timescale 1ns/1ps
module reference_synchroniser #(
	parameter int NUM_REFS = 4
) (
	// Clock and reset
	input  wire logic                clock_i,
	input  wire logic                reset_i,
	input  wire logic                ce_i,
	// Reference pins
	input  wire logic [NUM_REFS-1:0] ref_pins_i,
	// Towards the configuration logic
	ref_sync_if.syncer               bus
);

	wire  [NUM_REFS-1:0] stable_w;
	logic                level_q;

	// ==========================================================
	// Per-pin synchronisers
	genvar g;
	generate
		for (g = 0; g < NUM_REFS; g++) begin : gen_sync
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic keep_q;
			always_ff @(posedge clock_i or posedge reset_i) begin
				if (reset_i) begin
					s1_q   <= 1'b0;
					s2_q   <= 1'b0;
					s3_q   <= 1'b0;
					keep_q <= 1'b0;
				end else if (ce_i) begin
					s1_q <= ref_pins_i[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					// Accept a change only once two stages agree
					if (s2_q == s3_q) begin
						keep_q <= s3_q;
					end
				end
			end
			// Each pin owns its own flop; the vector is only a net
			assign stable_w[g] = keep_q;
		end
	endgenerate

	// ==========================================================
	// Source mux
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			level_q <= 1'b0;
		end else if (ce_i) begin
			level_q <= stable_w[bus.select];
		end
	end

	assign bus.level = level_q;

endmodule

// File: src/locked_loop_clock_config.sv
// Register file and enable sequencing for the frequency-locked loop.
// Assumes an APB master on clock_i; the oscillator itself is analogue.
`timescale 1ns/1ps
module locked_loop_clock_config
	import loop_cfg_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock, reset, enable
	input  wire logic              clock_i,
	input  wire logic              reset_i,
	input  wire logic              ce_i,
	// APB slave
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// Reference pins
	input  wire logic              mclk_pin_i,
	input  wire logic              playback_frame_clock_i,
	input  wire logic              record_frame_clock_i,
	input  wire logic              slow_crystal_reference_i,
	// Loop configuration
	output logic                   loop_analog_enable_o,
	output logic                   loop_digital_enable_o,
	output logic      [5:0]        output_divisor_o,
	output logic      [8:0]        loop_gain_o,
	output logic      [5:0]        control_rate_divisor_o,
	output logic      [4:0]        oscillator_ratio_o,
	output logic      [9:0]        integer_multiplier_o,
	output logic      [15:0]       fractional_multiplier_o,
	output logic                   fractional_mode_o,
	output logic                   low_reference_lock_o,
	output logic      [1:0]        loop_input_select_o,
	output logic                   loop_reference_o,
	output logic                   codec_clock_select_o
);

	function automatic logic addr_match(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
		return a == ADDR_W'({idx, 2'b00});
	endfunction

	// ==========================================================
	// Bus decode
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic [15:0] ctl1_q, ctl2_q, ctl3_q, ctl4_q;
	logic        clksel_q;
	logic        order_err_q;
	logic        resv_err_q;
	logic [7:0]  ref_count_q;
	logic        ref_prev_q;
	loop_state_t state_q, state_d;

	wire hit_clksel = addr_match(paddr_i, IDX_CLOCK_SELECT);
	wire hit_ctl1   = addr_match(paddr_i, IDX_ENABLES_DIVIDERS);
	wire hit_ctl2   = addr_match(paddr_i, IDX_RATIO_INTEGER);
	wire hit_ctl3   = addr_match(paddr_i, IDX_FRACTION);
	wire hit_ctl4   = addr_match(paddr_i, IDX_REFERENCE);
	wire hit_stat   = addr_match(paddr_i, IDX_STATUS);
	wire mapped     = hit_clksel | hit_ctl1 | hit_ctl2 | hit_ctl3 | hit_ctl4 | hit_stat;
	wire access     = psel_i & penable_i;
	// One wait state: data is prepared, then pready is raised for one cycle
	wire prepare    = access & ~pready_q;
	wire commit     = access & pready_q & pwrite_i & mapped;
	wire [15:0] wr  = pwdata_i[15:0];

	wire wr_clksel  = commit & hit_clksel;
	wire wr_ctl1    = commit & hit_ctl1;
	wire wr_ctl2    = commit & hit_ctl2;
	wire wr_ctl3    = commit & hit_ctl3;
	wire wr_ctl4    = commit & hit_ctl4;
	wire wr_stat    = commit & hit_stat;

	// ==========================================================
	// Status and read mux
	wire order_set  = wr_ctl1 & wr[CTL1_DIGITAL_BIT] & ~wr[CTL1_ANALOG_BIT];
	wire resv_set   = wr_ctl1 & (wr[CTL1_OUTDIV_HI:CTL1_OUTDIV_LO] > OUTDIV_MAX_CODE);
	// Set beats a write-one-to-clear in the same cycle
	wire order_d    = order_set | (order_err_q & ~(wr_stat & wr[STAT_ORDER_BIT]));
	wire resv_d     = resv_set | (resv_err_q & ~(wr_stat & wr[STAT_RESV_BIT]));

	logic [15:0] status_w;
	always_comb begin
		status_w = 16'h0000;
		status_w[STAT_LEVEL_BIT] = loop_reference_o;
		status_w[STAT_ORDER_BIT] = order_err_q;
		status_w[STAT_RESV_BIT]  = resv_err_q;
		status_w[STAT_OSC_BIT]   = (state_q != ST_OFF);
		status_w[STAT_RUN_BIT]   = (state_q == ST_RUN);
		status_w[STAT_COUNT_LO +: 8] = ref_count_q;
	end

	wire [15:0] clksel_w = 16'(clksel_q) << CLKSEL_BIT;
	wire [15:0] rd_w = ({16{hit_clksel}} & clksel_w) | ({16{hit_ctl1}} & ctl1_q)
		| ({16{hit_ctl2}} & ctl2_q) | ({16{hit_ctl3}} & ctl3_q)
		| ({16{hit_ctl4}} & ctl4_q) | ({16{hit_stat}} & status_w);

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else if (ce_i) begin
			pready_q  <= prepare;
			pslverr_q <= prepare & ~mapped;
			if (prepare) begin
				prdata_q <= {16'h0000, rd_w};
			end
		end
	end

	// ==========================================================
	// Control registers
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			ctl1_q      <= CTL1_RESET;
			ctl2_q      <= CTL2_RESET;
			ctl3_q      <= CTL3_RESET;
			ctl4_q      <= CTL4_RESET;
			clksel_q    <= 1'b0;
			order_err_q <= 1'b0;
			resv_err_q  <= 1'b0;
		end else if (ce_i) begin
			if (wr_ctl1) ctl1_q <= wr & CTL1_MASK;
			if (wr_ctl2) ctl2_q <= wr & CTL2_MASK;
			if (wr_ctl3) ctl3_q <= wr;
			if (wr_ctl4) ctl4_q <= wr & CTL4_MASK;
			if (wr_clksel) clksel_q <= wr[CLKSEL_BIT];
			order_err_q <= order_d;
			resv_err_q  <= resv_d;
		end
	end

	// ==========================================================
	// Enable sequencing
	wire ana_en = ctl1_q[CTL1_ANALOG_BIT];
	wire dig_en = ctl1_q[CTL1_DIGITAL_BIT];

	// Digital side only runs after the oscillator has been up a cycle
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_OFF: if (ana_en) state_d = ST_OSC;
			ST_OSC: begin
				if (!ana_en) state_d = ST_OFF;
				else if (dig_en) state_d = ST_RUN;
			end
			ST_RUN: begin
				if (!ana_en) state_d = ST_OFF;
				else if (!dig_en) state_d = ST_OSC;
			end
			default: state_d = ST_OFF;
		endcase
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) state_q <= ST_OFF;
		else if (ce_i) state_q <= state_d;
	end

	// ==========================================================
	// Field decoding
	wire [2:0] outdiv_code = ctl1_q[CTL1_OUTDIV_HI:CTL1_OUTDIV_LO];
	wire [3:0] gain_code   = ctl1_q[CTL1_GAIN_HI:CTL1_GAIN_LO];
	wire [2:0] rate_code   = ctl1_q[CTL1_RATE_HI:CTL1_RATE_LO];
	// Reserved codes give zero so downstream logic can spot them
	wire [5:0] outdiv_w = (outdiv_code <= OUTDIV_MAX_CODE) ? (OUTDIV_BASE << outdiv_code)
		: 6'h00;
	wire [8:0] gain_w   = (gain_code <= GAIN_MAX_CODE) ? (9'h001 << gain_code) : 9'h000;
	wire [5:0] rate_w   = (rate_code <= RATE_MAX_CODE) ? (6'h01 << rate_code) : 6'h00;
	wire       frac_on  = ctl4_q[CTL4_FRAC_BIT];
	wire [1:0] insel    = ctl4_q[CTL4_INSEL_HI:CTL4_INSEL_LO];

	ref_sync_if ref_bus ();
	assign ref_bus.select = insel;

	reference_synchroniser #(
		.NUM_REFS (4)
	) u_ref_sync (
		.clock_i    (clock_i),
		.reset_i    (reset_i),
		.ce_i       (ce_i),
		.ref_pins_i ({slow_crystal_reference_i, record_frame_clock_i,
			playback_frame_clock_i, mclk_pin_i}),
		.bus        (ref_bus)
	);

	// ==========================================================
	// Registered outputs
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			loop_analog_enable_o    <= 1'b0;
			loop_digital_enable_o   <= 1'b0;
			output_divisor_o        <= 6'h00;
			loop_gain_o             <= 9'h000;
			control_rate_divisor_o  <= 6'h00;
			oscillator_ratio_o      <= 5'h00;
			integer_multiplier_o    <= 10'h000;
			fractional_multiplier_o <= 16'h0000;
			fractional_mode_o       <= 1'b0;
			low_reference_lock_o    <= 1'b0;
			loop_input_select_o     <= 2'h0;
			loop_reference_o        <= 1'b0;
			codec_clock_select_o    <= 1'b0;
			ref_prev_q              <= 1'b0;
			ref_count_q             <= 8'h00;
		end else if (ce_i) begin
			loop_analog_enable_o    <= state_q != ST_OFF;
			loop_digital_enable_o   <= state_q == ST_RUN;
			output_divisor_o        <= outdiv_w;
			loop_gain_o             <= gain_w;
			control_rate_divisor_o  <= rate_w;
			oscillator_ratio_o      <= ctl2_q[CTL2_RATIO_HI:CTL2_RATIO_LO];
			integer_multiplier_o    <= ctl2_q[CTL2_N_HI:CTL2_N_LO];
			fractional_multiplier_o <= frac_on ? ctl3_q : 16'h0000;
			fractional_mode_o       <= frac_on;
			low_reference_lock_o    <= ctl4_q[CTL4_LOWREF_BIT];
			loop_input_select_o     <= insel;
			loop_reference_o        <= ref_bus.level;
			codec_clock_select_o    <= clksel_q;
			ref_prev_q              <= ref_bus.level;
			// Reference edges are only counted while the oscillator is up
			if (ref_bus.level && !ref_prev_q && state_q != ST_OFF) begin
				ref_count_q <= ref_count_q + 8'h01;
			end
		end
	end

	assign prdata_o  = prdata_q;
	assign pready_o  = pready_q;
	assign pslverr_o = pslverr_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock_i iff ce_i); endclocking
	default disable iff (reset_i);

	digital_seq_a: assert property ((dig_en && ana_en) [*3]
		|=> loop_digital_enable_o)
		else $error("digital enable not reached after three cycles");
	analog_off_a: assert property (!ana_en
		|-> ##2 !loop_digital_enable_o)
		else $error("digital enable survives analogue off");
	order_flag_a: assert property (order_set
		|=> order_err_q)
		else $error("order error not flagged");
	outdiv_max_a: assert property (outdiv_code == OUTDIV_MAX_CODE
		|=> output_divisor_o == 6'h20)
		else $error("output divider code four not divide by 32");
	gain_max_a: assert property (gain_code == GAIN_MAX_CODE
		|=> loop_gain_o == 9'h100)
		else $error("loop gain code eight not x256");
	rate_max_a: assert property (rate_code == RATE_MAX_CODE
		|=> control_rate_divisor_o == 6'h20)
		else $error("control rate code five not divide by 32");
	ratio_write_a: assert property (wr_ctl2
		|-> ##2 oscillator_ratio_o == $past(wr[CTL2_RATIO_HI:CTL2_RATIO_LO], 2))
		else $error("oscillator ratio did not follow write");
	n_write_a: assert property (wr_ctl2
		|-> ##2 integer_multiplier_o == $past(wr[CTL2_N_HI:CTL2_N_LO], 2))
		else $error("integer multiplier did not follow write");
	frac_gate_a: assert property (!frac_on
		|=> fractional_multiplier_o == 16'h0000)
		else $error("fractional multiplier leaks in integer mode");
	frac_mode_a: assert property (wr_ctl4
		|-> ##2 fractional_mode_o == $past(wr[CTL4_FRAC_BIT], 2))
		else $error("fractional mode did not follow write");
	lowref_a: assert property (wr_ctl4
		|-> ##2 low_reference_lock_o == $past(wr[CTL4_LOWREF_BIT], 2))
		else $error("reference lock select did not follow write");
	insel_a: assert property (wr_ctl4
		|-> ##2 loop_input_select_o == $past(wr[CTL4_INSEL_HI:CTL4_INSEL_LO], 2))
		else $error("input select did not follow write");
	clksel_a: assert property (wr_clksel
		|-> ##2 codec_clock_select_o == $past(wr[CLKSEL_BIT], 2))
		else $error("codec clock select did not follow write");

	run_reached_c: cover property (state_q == ST_OSC ##1 state_q == ST_RUN);
	frac_used_c: cover property (loop_digital_enable_o && fractional_mode_o);
	order_err_c: cover property (order_set);
	unmapped_c: cover property (pready_o && pslverr_o);

endmodule

// File: test/test_locked_loop_clock_config.sv
// Self-checking bench for the locked-loop clock configuration block.
// Assumes the APB answer comes with one wait state; the bench only waits for pready_o.
`timescale 1ns/1ps
module test_locked_loop_clock_config;
	import loop_cfg_pkg::*;

	// ==========================================================
	// Signals
	typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} note_t;
	logic        clock_i, reset_i, ce_i, psel_i, penable_i, pwrite_i;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o;
	logic        pready_o, pslverr_o, loop_analog_enable_o, loop_digital_enable_o;
	logic [3:0]  pins;
	logic [5:0]  output_divisor_o, control_rate_divisor_o;
	logic [8:0]  loop_gain_o;
	logic [4:0]  oscillator_ratio_o, r;
	logic [9:0]  integer_multiplier_o, nm;
	logic [15:0] fractional_multiplier_o, v, k;
	logic        fractional_mode_o, low_reference_lock_o, loop_reference_o, codec_clock_select_o;
	logic [1:0]  loop_input_select_o;
	note_t       notes[$];
	note_t       nt;
	int          error_cnt, compares, seed, od, rt;

	locked_loop_clock_config #(.ADDR_W(12)) u_locked_loop_clock_config (
		.clock_i(clock_i), .reset_i(reset_i), .ce_i(ce_i), .paddr_i(paddr_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.mclk_pin_i(pins[0]), .playback_frame_clock_i(pins[1]),
		.record_frame_clock_i(pins[2]), .slow_crystal_reference_i(pins[3]),
		.loop_analog_enable_o(loop_analog_enable_o),
		.loop_digital_enable_o(loop_digital_enable_o), .output_divisor_o(output_divisor_o),
		.loop_gain_o(loop_gain_o), .control_rate_divisor_o(control_rate_divisor_o),
		.oscillator_ratio_o(oscillator_ratio_o), .integer_multiplier_o(integer_multiplier_o),
		.fractional_multiplier_o(fractional_multiplier_o), .fractional_mode_o(fractional_mode_o),
		.low_reference_lock_o(low_reference_lock_o), .loop_input_select_o(loop_input_select_o),
		.loop_reference_o(loop_reference_o), .codec_clock_select_o(codec_clock_select_o));

	// ==========================================================
	// Tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up;
		if (notes.size() != 0)
			error_cnt++;
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Notes the expected answer first, so the monitor can pop it at pready
	task automatic apb(input logic [9:0] idx, input logic wr, input logic [15:0] wd,
			input logic [31:0] exp, input logic [31:0] msk, input logic err);
		int n;
		notes.push_back('{exp, msk, err});
		@(posedge clock_i);
		paddr_i   <= {idx, 2'b00};
		pwrite_i  <= wr;
		pwdata_i  <= {16'h0000, wd};
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		@(posedge clock_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		check("apb answer", 32'(n < 50), 32'h1);
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic wr(input logic [9:0] idx, input logic [15:0] d);
		apb(idx, 1'b1, d, 32'h0, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic [31:0] msk);
		apb(idx, 1'b0, 16'h0000, exp, msk, 1'b0);
	endtask

	// Derived outputs lag the register by one edge, the enables by two; four leaves margin
	task automatic settle;
		repeat (4) @(posedge clock_i);
		#1;
	endtask

	task automatic do_reset;
		@(posedge clock_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		reset_i <= 1'b0;
	endtask

	// ==========================================================
	// Clock, monitor, watchdog
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	always @(posedge clock_i) begin
		if (pready_o === 1'b1 && psel_i && penable_i) begin
			if (notes.size() == 0) begin
				check("unexpected answer", 32'h1, 32'h0);
			end else begin
				nt = notes.pop_front();
				check("read data", prdata_o & nt.mask, nt.data & nt.mask);
				check("slave error", 32'(pslverr_o), 32'(nt.err));
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clock_i);
		error_cnt++;
		wrap_up();
	end

	// ==========================================================
	// Scenarios
	initial begin
		seed = 40;
		reset_i = 1'b1;
		ce_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		pins = 4'h0;
		repeat (2) @(posedge clock_i);
		reset_i <= 1'b0;
		settle();
		check("digital enable", 32'(loop_digital_enable_o), 32'h0);
		check("analog enable", 32'(loop_analog_enable_o), 32'h0);
		check("divisor", 32'(output_divisor_o), 32'h8);
		check("gain", 32'(loop_gain_o), 32'h1);
		check("rate", 32'(control_rate_divisor_o), 32'h1);
		check("ratio", 32'(oscillator_ratio_o), 32'he);
		check("multiplier", 32'(integer_multiplier_o), 32'h86);
		check("fraction", 32'(fractional_multiplier_o), 32'h0);
		check("frac mode", 32'(fractional_mode_o), 32'h0);
		check("low ref", 32'(low_reference_lock_o), 32'h0);
		check("input sel", 32'(loop_input_select_o), 32'h0);
		check("codec sel", 32'(codec_clock_select_o), 32'h0);
		rd(IDX_ENABLES_DIVIDERS, 32'h0200, 32'hffffffff);
		rd(IDX_RATIO_INTEGER, 32'h7086, 32'hffffffff);
		rd(IDX_FRACTION, 32'hc226, 32'hffffffff);
		rd(IDX_REFERENCE, 32'h0000, 32'hffffffff);
		for (int i = 0; i < 9; i++) begin
			od = i % 5;
			rt = i % 6;
			v = 16'((od << 8) | (i << 4) | rt);
			wr(IDX_ENABLES_DIVIDERS, v);
			settle();
			check("divisor", 32'(output_divisor_o), 32'(OUTDIV_BASE) << od);
			check("gain", 32'(loop_gain_o), 32'h1 << i);
			check("rate", 32'(control_rate_divisor_o), 32'h1 << rt);
			rd(IDX_ENABLES_DIVIDERS, 32'(v), 32'hffffffff);
		end
		// Reserved divider code is software's fault; it is kept and flagged
		wr(IDX_ENABLES_DIVIDERS, 16'h0700);
		rd(IDX_ENABLES_DIVIDERS, 32'h0700, 32'hffffffff);
		rd(IDX_STATUS, 32'h4, 32'h4);
		wr(IDX_ENABLES_DIVIDERS, 16'h0200);
		for (int i = 0; i < 4; i++) begin
			r = (i == 0) ? 5'd1 : (i == 1) ? 5'd8 : 5'($random(seed));
			nm = 10'($random(seed));
			v = {r, 1'b0, nm};
			wr(IDX_RATIO_INTEGER, v);
			settle();
			check("ratio", 32'(oscillator_ratio_o), 32'(r));
			check("multiplier", 32'(integer_multiplier_o), 32'(nm));
			rd(IDX_RATIO_INTEGER, 32'(v), 32'hffffffff);
		end
		k = 16'($random(seed));
		wr(IDX_FRACTION, k);
		settle();
		check("fraction", 32'(fractional_multiplier_o), 32'h0);
		rd(IDX_FRACTION, 32'(k), 32'hffffffff);
		for (int i = 0; i < 4; i++) begin
			v = 16'(((i & 1) << 7) | 32'h20 | i);
			wr(IDX_REFERENCE, v);
			settle();
			check("frac mode", 32'(fractional_mode_o), 32'h1);
			check("fraction", 32'(fractional_multiplier_o), 32'(k));
			check("low ref", 32'(low_reference_lock_o), 32'(i & 1));
			check("input sel", 32'(loop_input_select_o), 32'(i));
			@(posedge clock_i);
			pins <= 4'(1 << i);
			repeat (10) @(posedge clock_i);
			#1;
			check("reference", 32'(loop_reference_o), 32'h1);
			@(posedge clock_i);
			pins <= ~4'(1 << i);
			repeat (10) @(posedge clock_i);
			#1;
			check("reference", 32'(loop_reference_o), 32'h0);
		end
		wr(IDX_REFERENCE, 16'h0000);
		settle();
		check("fraction", 32'(fractional_multiplier_o), 32'h0);
		wr(IDX_CLOCK_SELECT, 16'h0800);
		settle();
		check("codec sel", 32'(codec_clock_select_o), 32'h1);
		rd(IDX_CLOCK_SELECT, 32'h0800, 32'h0800);
		wr(IDX_CLOCK_SELECT, 16'h0000);
		settle();
		check("codec sel", 32'(codec_clock_select_o), 32'h0);
		// Digital without analogue must be held off
		wr(IDX_ENABLES_DIVIDERS, 16'h8200);
		settle();
		check("digital enable", 32'(loop_digital_enable_o), 32'h0);
		check("analog enable", 32'(loop_analog_enable_o), 32'h0);
		rd(IDX_STATUS, 32'h2, 32'h2);
		wr(IDX_ENABLES_DIVIDERS, 16'h4200);
		settle();
		check("analog enable", 32'(loop_analog_enable_o), 32'h1);
		check("digital enable", 32'(loop_digital_enable_o), 32'h0);
		rd(IDX_STATUS, 32'h08, 32'h18);
		wr(IDX_ENABLES_DIVIDERS, 16'hc200);
		settle();
		check("digital enable", 32'(loop_digital_enable_o), 32'h1);
		rd(IDX_STATUS, 32'h18, 32'h18);
		wr(IDX_ENABLES_DIVIDERS, 16'h0200);
		settle();
		check("analog enable", 32'(loop_analog_enable_o), 32'h0);
		check("digital enable", 32'(loop_digital_enable_o), 32'h0);
		// Sticky flags clear on a write of ones; level bit follows the pin
		wr(IDX_STATUS, 16'h0006);
		rd(IDX_STATUS, 32'h1, 32'h7);
		// Unmapped place: refused both ways, nothing changes
		apb(10'h3ff, 1'b0, 16'h0000, 32'h0, 32'hffffffff, 1'b1);
		apb(10'h3ff, 1'b1, 16'hffff, 32'h0, 32'h0, 1'b1);
		rd(IDX_ENABLES_DIVIDERS, 32'h0200, 32'hffffffff);
		// Clock enable low freezes the synchroniser, so a pin change waits
		@(posedge clock_i);
		ce_i <= 1'b0;
		pins <= 4'h0;
		repeat (10) @(posedge clock_i);
		#1;
		check("frozen ref", 32'(loop_reference_o), 32'h1);
		@(posedge clock_i);
		ce_i <= 1'b1;
		repeat (10) @(posedge clock_i);
		#1;
		check("reference", 32'(loop_reference_o), 32'h0);
		wr(IDX_FRACTION, 16'h1234);
		do_reset();
		settle();
		rd(IDX_FRACTION, 32'hc226, 32'hffffffff);
		check("divisor", 32'(output_divisor_o), 32'h8);
		repeat (3) @(posedge clock_i);
		wrap_up();
	end
endmodule
